/* File: design/slpm_pkg.sv */
// constants and types shared by the sleep and power manager
package slpm_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BOD_WAKE_NS = 60_000;
  localparam int BOD_WAKE_CYC =
    (BOD_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HALT_CYC = 4;
  localparam int STBY_CYC = 6;
  localparam int OSC_START_CYC = 64;
  localparam logic [9:0] WAKE_HALT = 10'(HALT_CYC);
  localparam logic [9:0] WAKE_STBY = 10'(STBY_CYC);
  localparam logic [9:0] WAKE_PDOWN = 10'(OSC_START_CYC + HALT_CYC);
  localparam logic [9:0] WAKE_BOD = 10'(BOD_WAKE_CYC);
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  localparam logic [2:0] BROWNOUT_SLEEP_OFF_DLY_CYC = 3'h3;
  localparam logic [2:0] BROWNOUT_SLEEP_OFF_HOLD_CYC = 3'h3;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CORE = 5'h00;
  localparam logic [4:0] OFS_PCLK = 5'h04;
  localparam logic [4:0] OFS_DISA = 5'h08;
  localparam logic [4:0] OFS_DISB = 5'h0c;
  localparam logic [4:0] OFS_ACMP = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam int CC_BROWNOUT_SLEEP_OFF = 7;
  localparam int CC_SE = 5;
  localparam int CC_SM_HI = 4;
  localparam int CC_SM_LO = 3;
  localparam int CC_BROWNOUT_SLEEP_UNLOCK = 2;
  localparam int AC_OFF = 7;
  localparam int AC_REF = 6;
  localparam logic [7:0] CORE_RST = 8'h00;
  localparam logic [3:0] PCLK_RST = 4'h0;
  localparam logic [7:0] DIS_RST = 8'h00;
  localparam logic [7:0] ACMP_RST = 8'h00;

  // ------------------------------------------------------------
  // modes, states and carriers
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ADCNR = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_STBY = 2'h3;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_ENTER = 2'b01,
    ST_SLEEP = 2'b11,
    ST_WAKE = 2'b10
  } slpm_state_t;

  typedef struct packed {
    logic osc;
    logic adc;
    logic io;
    logic flash;
    logic cpu;
  } slpm_clk_t;

  typedef struct packed {
    logic any_irq;
    logic adc_done;
    logic nvm_ready;
    logic wdt_irq;
  } slpm_wake_t;

  // power-down and standby share most behaviour
  function automatic logic slpm_is_deep(input logic [1:0] m);
    return m[1];
  endfunction

endpackage

/* File: design/slpm_top.sv */
// sleep and power manager: mode sequencing, clock gating, wake-up
`timescale 1ns/10ps

module slpm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_exec,
  input wire slpm_pkg::slpm_wake_t wake_src,
  input wire logic ext0_level_pin,
  input wire logic pin_change_pin,
  input wire logic adc_enabled,
  input wire logic wdt_enabled,
  input wire logic bod_fuse_en,
  input wire logic xtal_selected,
  input wire logic [15:0] wake_pin_need,
  output slpm_pkg::slpm_clk_t clk_en,
  output logic [3:0] periph_clk_en,
  output logic [3:0] periph_reg_en,
  output logic bod_en,
  output logic comp_en,
  output logic vref_en,
  output logic adc_start,
  output logic adc_extended,
  output logic wdt_run,
  output logic [15:0] in_buf_en
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  slpm_pkg::slpm_state_t state_r;
  slpm_pkg::slpm_state_t state_nxt;
  slpm_pkg::slpm_clk_t clk_nxt;
  logic [1:0] mode_eff_r;
  logic [7:0] core_r;
  logic [3:0] pclk_r;
  logic [7:0] disa_r;
  logic [7:0] disb_r;
  logic [7:0] acmp_r;
  logic [2:0] unlock_cnt_r;
  logic [2:0] dly_cnt_r;
  logic [2:0] act_cnt_r;
  logic bod_off_sleep_r;
  logic [9:0] wake_cnt_r;
  logic [1:0] sy0_r;
  logic [1:0] sy1_r;
  logic [1:0] sy2_r;
  logic [1:0] pin_f_r;
  logic adc_en_d_r;

  function automatic logic [2:0] dec3(input logic [2:0] v);
    return (v == 3'h0) ? 3'h0 : v - 3'h1;
  endfunction

  // ------------------------------------------------------------
  // bus slave decode
  // ------------------------------------------------------------
  // one wait cycle per access keeps read data registered
  wire req = avs_read | avs_write;
  wire wr_acc = avs_write & ~avs_waitrequest;
  wire wr_core = wr_acc & (avs_address == slpm_pkg::OFS_CORE);
  wire wr_pclk = wr_acc & (avs_address == slpm_pkg::OFS_PCLK);
  wire wr_disa = wr_acc & (avs_address == slpm_pkg::OFS_DISA);
  wire wr_disb = wr_acc & (avs_address == slpm_pkg::OFS_DISB);
  wire wr_acmp = wr_acc & (avs_address == slpm_pkg::OFS_ACMP);
  wire brownout_sleep_off_act = act_cnt_r != 3'h0;
  wire unlock_on = unlock_cnt_r != 3'h0;
  wire [7:0] core_rd = {brownout_sleep_off_act, core_r[6:3], unlock_on, core_r[1:0]};
  wire [7:0] stat_rd = {state_r, mode_eff_r, bod_en, comp_en, vref_en,
                        bod_off_sleep_r};
  wire [7:0] rd_byte =
    (avs_address == slpm_pkg::OFS_CORE) ? core_rd :
    (avs_address == slpm_pkg::OFS_PCLK) ? {4'h0, pclk_r} :
    (avs_address == slpm_pkg::OFS_DISA) ? disa_r :
    (avs_address == slpm_pkg::OFS_DISB) ? disb_r :
    (avs_address == slpm_pkg::OFS_ACMP) ? acmp_r :
    (avs_address == slpm_pkg::OFS_STAT) ? stat_rd : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= {24'h0, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_r <= slpm_pkg::CORE_RST;
      pclk_r <= slpm_pkg::PCLK_RST;
      disa_r <= slpm_pkg::DIS_RST;
      disb_r <= slpm_pkg::DIS_RST;
      acmp_r <= slpm_pkg::ACMP_RST;
    end else begin
      if (wr_core)
        core_r <= avs_writedata[7:0];
      if (wr_pclk)
        pclk_r <= avs_writedata[3:0];
      if (wr_disa)
        disa_r <= avs_writedata[7:0];
      if (wr_disb)
        disb_r <= avs_writedata[7:0];
      if (wr_acmp)
        acmp_r <= avs_writedata[7:0];
    end
  end

  // ------------------------------------------------------------
  // timed brown-out sleep unlock
  // ------------------------------------------------------------
  wire brownout_sleep_off_wd = avs_writedata[slpm_pkg::CC_BROWNOUT_SLEEP_OFF];
  wire brownout_sleep_unlock_wd = avs_writedata[slpm_pkg::CC_BROWNOUT_SLEEP_UNLOCK];
  wire unlock_set = wr_core & brownout_sleep_off_wd & brownout_sleep_unlock_wd;
  // a second arm while one is in flight is ignored
  wire brownout_sleep_off_arm = wr_core & brownout_sleep_off_wd & ~brownout_sleep_unlock_wd & unlock_on &
                  (dly_cnt_r == 3'h0) & ~brownout_sleep_off_act;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unlock_cnt_r <= 3'h0;
      dly_cnt_r <= 3'h0;
      act_cnt_r <= 3'h0;
    end else begin
      unlock_cnt_r <= unlock_set ? slpm_pkg::UNLOCK_CYC : dec3(unlock_cnt_r);
      dly_cnt_r <= brownout_sleep_off_arm ? slpm_pkg::BROWNOUT_SLEEP_OFF_DLY_CYC : dec3(dly_cnt_r);
      if (dly_cnt_r == 3'h1)
        act_cnt_r <= slpm_pkg::BROWNOUT_SLEEP_OFF_HOLD_CYC;
      else
        act_cnt_r <= dec3(act_cnt_r);
    end
  end

  // ------------------------------------------------------------
  // wake pin synchronisers
  // ------------------------------------------------------------
  // a change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sy0_r <= 2'h0;
      sy1_r <= 2'h0;
      sy2_r <= 2'h0;
      pin_f_r <= 2'h0;
    end else begin
      sy0_r <= {pin_change_pin, ext0_level_pin};
      sy1_r <= sy0_r;
      sy2_r <= sy1_r;
      pin_f_r <= (sy1_r & sy2_r) | (pin_f_r & (sy1_r | sy2_r));
    end
  end

  // ------------------------------------------------------------
  // sleep entry and wake qualification
  // ------------------------------------------------------------
  wire [1:0] mode_sel = core_r[slpm_pkg::CC_SM_HI:slpm_pkg::CC_SM_LO];
  // mode 11 without a crystal clock falls back to power-down
  wire [1:0] mode_go = (mode_sel == slpm_pkg::MODE_STBY && !xtal_selected)
                       ? slpm_pkg::MODE_PDOWN : mode_sel;
  wire sleep_go = sleep_exec & core_r[slpm_pkg::CC_SE] &
                  (state_r == slpm_pkg::ST_ACTIVE);
  wire deep_eff = slpm_pkg::slpm_is_deep(mode_eff_r);
  wire wake_deep = pin_f_r[0] | pin_f_r[1] | wake_src.wdt_irq;
  wire wake_adcnr = wake_deep | wake_src.adc_done |
                    wake_src.nvm_ready;
  wire wake_idle = wake_adcnr | wake_src.any_irq;
  wire wake_ok = deep_eff ? wake_deep :
                 (mode_eff_r == slpm_pkg::MODE_ADCNR) ? wake_adcnr :
                 wake_idle;
  wire [9:0] len_base =
    (mode_eff_r == slpm_pkg::MODE_PDOWN) ? slpm_pkg::WAKE_PDOWN :
    (mode_eff_r == slpm_pkg::MODE_STBY) ? slpm_pkg::WAKE_STBY :
    slpm_pkg::WAKE_HALT;
  wire [9:0] wake_len = (bod_off_sleep_r && len_base < slpm_pkg::WAKE_BOD)
                        ? slpm_pkg::WAKE_BOD : len_base;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      slpm_pkg::ST_ACTIVE: begin
        if (sleep_go)
          state_nxt = slpm_pkg::ST_ENTER;
      end
      slpm_pkg::ST_ENTER: begin
        state_nxt = wake_ok ? slpm_pkg::ST_WAKE : slpm_pkg::ST_SLEEP;
      end
      slpm_pkg::ST_SLEEP: begin
        if (wake_ok)
          state_nxt = slpm_pkg::ST_WAKE;
      end
      slpm_pkg::ST_WAKE: begin
        if (wake_cnt_r == 10'h1)
          state_nxt = slpm_pkg::ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= slpm_pkg::ST_ACTIVE;
      mode_eff_r <= slpm_pkg::MODE_IDLE;
      bod_off_sleep_r <= 1'b0;
      wake_cnt_r <= 10'h0;
    end else begin
      state_r <= state_nxt;
      if (sleep_go) begin
        mode_eff_r <= mode_go;
        bod_off_sleep_r <= brownout_sleep_off_act & slpm_pkg::slpm_is_deep(mode_go);
      end else if (state_nxt == slpm_pkg::ST_ACTIVE) begin
        bod_off_sleep_r <= 1'b0;
      end
      if (state_r != slpm_pkg::ST_WAKE && state_nxt == slpm_pkg::ST_WAKE)
        wake_cnt_r <= wake_len;
      else if (wake_cnt_r != 10'h0)
        wake_cnt_r <= wake_cnt_r - 10'h1;
    end
  end

  // ------------------------------------------------------------
  // clock domain enables
  // ------------------------------------------------------------
  // cpu and flash stop one cycle before the rest, and on wake the
  // oscillator and peripheral clocks return before the core
  wire nxt_sleep = state_nxt == slpm_pkg::ST_SLEEP;
  wire nxt_core = state_nxt == slpm_pkg::ST_ACTIVE;
  wire mode_idle = mode_eff_r == slpm_pkg::MODE_IDLE;
  wire mode_adcnr = mode_eff_r == slpm_pkg::MODE_ADCNR;

  always_comb begin
    clk_nxt.cpu = nxt_core;
    clk_nxt.flash = nxt_core;
    clk_nxt.io = ~nxt_sleep | mode_idle;
    clk_nxt.adc = ~nxt_sleep | mode_idle | mode_adcnr;
    clk_nxt.osc = ~nxt_sleep |
                  (mode_eff_r != slpm_pkg::MODE_PDOWN);
  end

  wire nxt_deep = nxt_sleep & deep_eff;
  wire comp_off = acmp_r[slpm_pkg::AC_OFF];
  wire comp_nxt = ~comp_off & ~nxt_deep;
  wire bod_nxt = bod_fuse_en & ~(nxt_sleep & bod_off_sleep_r);
  wire ref_hold = ~comp_off & acmp_r[slpm_pkg::AC_REF];
  wire buf_stop = nxt_sleep & ~clk_nxt.io & ~clk_nxt.adc;
  wire [15:0] buf_nxt = ~{disb_r, disa_r} &
                        ~({16{buf_stop}} & ~wake_pin_need);
  wire [3:0] pclk_src = {clk_nxt.io, clk_nxt.io, clk_nxt.io, clk_nxt.adc};
  wire adc_go = sleep_go & ~slpm_pkg::slpm_is_deep(mode_go) & adc_enabled;

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_en <= '1;
      periph_clk_en <= 4'hf;
      periph_reg_en <= 4'hf;
      bod_en <= 1'b0;
      comp_en <= 1'b0;
      vref_en <= 1'b0;
      adc_start <= 1'b0;
      adc_extended <= 1'b0;
      adc_en_d_r <= 1'b0;
      wdt_run <= 1'b0;
      in_buf_en <= 16'h0;
    end else begin
      clk_en <= clk_nxt;
      // stop bits and sleep gating both act; state is held by the
      // stopped clock, so clearing a bit resumes where it left off
      periph_clk_en <= pclk_src & ~pclk_r;
      periph_reg_en <= ~pclk_r;
      bod_en <= bod_nxt;
      comp_en <= comp_nxt;
      vref_en <= bod_nxt | comp_nxt | ref_hold | adc_enabled;
      adc_start <= adc_go;
      adc_en_d_r <= adc_enabled;
      // a new enable wins over a completion in the same cycle
      adc_extended <= (adc_enabled & ~adc_en_d_r) |
                      (adc_extended & ~wake_src.adc_done);
      wdt_run <= wdt_enabled;
      in_buf_en <= buf_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  idle_clocks_a: assert property (
    state_r == slpm_pkg::ST_SLEEP && mode_idle |->
      !clk_en.cpu && !clk_en.flash && clk_en.io && clk_en.adc)
    else $error("idle clock gating wrong");

  adcnr_clocks_a: assert property (
    state_r == slpm_pkg::ST_SLEEP && mode_adcnr |->
      !clk_en.io && !clk_en.cpu && clk_en.adc)
    else $error("noise reduction clock gating wrong");

  pdown_osc_a: assert property (
    state_r == slpm_pkg::ST_SLEEP && mode_eff_r == slpm_pkg::MODE_PDOWN
      |-> !clk_en.osc && !clk_en.io && !clk_en.adc)
    else $error("power-down left a clock running");

  wake_halt_a: assert property (
    $rose(state_r == slpm_pkg::ST_WAKE) && !deep_eff && !bod_off_sleep_r
      |-> !clk_en.cpu [*4] ##1 clk_en.cpu)
    else $error("core halt after wake not four cycles");

  stby_wake_a: assert property (
    $rose(state_r == slpm_pkg::ST_WAKE) &&
      mode_eff_r == slpm_pkg::MODE_STBY && !bod_off_sleep_r
      |-> ##[1:6] clk_en.cpu)
    else $error("standby wake slower than six cycles");

  bod_sleep_a: assert property (
    state_r == slpm_pkg::ST_SLEEP && bod_off_sleep_r |-> !bod_en)
    else $error("detector still on in disabled sleep");

  bod_stretch_a: assert property (
    $rose(state_r == slpm_pkg::ST_WAKE) && bod_off_sleep_r
      |-> wake_cnt_r >= slpm_pkg::WAKE_BOD)
    else $error("wake not stretched after detector disable");

  brownout_sleep_off_timing_a: assert property (
    brownout_sleep_off_arm |-> ##1 !brownout_sleep_off_act [*3] ##1 brownout_sleep_off_act [*3] ##1 !brownout_sleep_off_act)
    else $error("brown-out sleep bit timing wrong");

  deep_periph_a: assert property (
    state_r == slpm_pkg::ST_SLEEP && deep_eff |->
      periph_clk_en == 4'h0 && !comp_en)
    else $error("peripheral or comparator alive in deep sleep");

  adc_auto_a: assert property (
    adc_go |=> adc_start ##1 !adc_start)
    else $error("conversion not started on sleep entry");

  fuse_bod_a: assert property (
    state_r == slpm_pkg::ST_ACTIVE && $past(state_r) == slpm_pkg::ST_ACTIVE
      && $past(rst_n) |-> bod_en == $past(bod_fuse_en))
    else $error("detector does not follow fuse while active");

endmodule

/* File: testbench/slpm_top_tb_top.sv */
// self-checking bench for the sleep and power manager
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("unexpected %s expected %h seen %h", n, e, g); \
  end \
end

module slpm_top_tb_top;
  logic clk, rst_n, avs_read, avs_write, sleep_exec;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, ext0_level_pin, pin_change_pin, adc_enabled;
  logic wdt_enabled, bod_fuse_en, xtal_selected;
  logic [15:0] wake_pin_need, in_buf_en;
  slpm_pkg::slpm_wake_t wake_src;
  slpm_pkg::slpm_clk_t clk_en;
  logic [3:0] periph_clk_en, periph_reg_en;
  logic bod_en, comp_en, vref_en, adc_start, adc_extended, wdt_run;
  int errors = 0;
  int samples_checked = 0;

  slpm_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_exec(sleep_exec),
    .wake_src(wake_src), .ext0_level_pin(ext0_level_pin),
    .pin_change_pin(pin_change_pin), .adc_enabled(adc_enabled),
    .wdt_enabled(wdt_enabled), .bod_fuse_en(bod_fuse_en),
    .xtal_selected(xtal_selected), .wake_pin_need(wake_pin_need),
    .clk_en(clk_en), .periph_clk_en(periph_clk_en),
    .periph_reg_en(periph_reg_en), .bod_en(bod_en), .comp_en(comp_en),
    .vref_en(vref_en), .adc_start(adc_start),
    .adc_extended(adc_extended), .wdt_run(wdt_run), .in_buf_en(in_buf_en));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // leading edge keeps back-to-back calls from driving twice in one step
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      test_done;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK("readdata", e, q)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic enter(input logic [4:0] ce, input logic st);
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
    `CHK("cpu_flash_en", 2'b00, {clk_en.flash, clk_en.cpu})
    `CHK("adc_start", st, adc_start)
    settle(1);
    `CHK("clk_en", ce, clk_en)
  endtask

  task automatic count_wake(input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (clk_en.cpu !== 1'b1) begin
      n++;
      if (n > 2000) begin
        errors++;
        test_done;
      end
      settle(1);
    end
    `CHK("wake_cycles_in_bound", 1'b1, n >= lo && n <= hi)
  endtask

  task automatic wake_pulse(input logic [3:0] v, input int lo, input int hi);
    @(posedge clk);
    wake_src <= v;
    @(posedge clk);
    wake_src <= 4'h0;
    count_wake(lo, hi);
  endtask

  // pin requests pass a synchroniser, so allow its latency
  task automatic pin_wake(input logic pc, input int lo, input int hi);
    @(posedge clk);
    pin_change_pin <= pc;
    ext0_level_pin <= !pc;
    @(posedge clk);
    count_wake(lo, hi);
    @(posedge clk);
    pin_change_pin <= 1'b0;
    ext0_level_pin <= 1'b0;
  endtask

  task automatic ignored(input logic [3:0] v);
    @(posedge clk);
    wake_src <= v;
    @(posedge clk);
    wake_src <= 4'h0;
    settle(6);
    `CHK("still_asleep", 1'b0, clk_en.cpu)
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    `CHK("clk_en", 5'h1f, clk_en)
    `CHK("in_buf_en", 16'hffff, in_buf_en)
    `CHK("periph_clk_en", 4'hf, periph_clk_en)
    `CHK("wdt_run", 1'b1, wdt_run)
    `CHK("bod_en", 1'b1, bod_en)
    `CHK("vref_en", 1'b1, vref_en)
    for (int i = 0; i < 5; i++) begin
      rd_chk(5'(4 * i), 32'h0);
    end
    rd_chk(slpm_pkg::OFS_STAT, 32'h0000000e);
    wr(5'h18, 32'hff);
    rd_chk(5'h18, 32'h0);
  endtask

  task automatic t_refuse;
    wr(slpm_pkg::OFS_CORE, 32'h00);
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    settle(2);
    `CHK("cpu_runs", 1'b1, clk_en.cpu)
  endtask

  task automatic t_adc_ext;
    @(posedge clk);
    adc_enabled <= 1'b1;
    settle(2);
    `CHK("adc_extended", 1'b1, adc_extended)
    wake_pulse(4'h4, 0, 0);
    settle(1);
    `CHK("adc_extended", 1'b0, adc_extended)
  endtask

  task automatic t_idle;
    wr(slpm_pkg::OFS_CORE, 32'h20);
    enter(5'b11100, 1'b1);
    wake_pulse(4'h8, slpm_pkg::HALT_CYC, slpm_pkg::HALT_CYC);
  endtask

  task automatic t_noise;
    wr(slpm_pkg::OFS_CORE, 32'h28);
    enter(5'b11000, 1'b1);
    ignored(4'h8);
    wake_pulse(4'h4, slpm_pkg::HALT_CYC, slpm_pkg::HALT_CYC);
  endtask

  task automatic t_pclk;
    wr(slpm_pkg::OFS_PCLK, 32'hff);
    settle(2);
    `CHK("periph_clk_en", 4'h0, periph_clk_en)
    `CHK("periph_reg_en", 4'h0, periph_reg_en)
    rd_chk(slpm_pkg::OFS_PCLK, 32'h0f);
    wr(slpm_pkg::OFS_PCLK, 32'h05);
    settle(2);
    `CHK("periph_clk_en", 4'ha, periph_clk_en)
    `CHK("periph_reg_en", 4'ha, periph_reg_en)
    wr(slpm_pkg::OFS_PCLK, 32'h00);
  endtask

  task automatic t_pdown;
    wr(slpm_pkg::OFS_DISA, 32'h0f);
    wr(slpm_pkg::OFS_DISB, 32'h80);
    settle(2);
    `CHK("in_buf_en", 16'h7ff0, in_buf_en)
    wr(slpm_pkg::OFS_CORE, 32'h30);
    enter(5'b00000, 1'b0);
    `CHK("in_buf_en", 16'h0100, in_buf_en)
    `CHK("comp_en", 1'b0, comp_en)
    `CHK("bod_en", 1'b1, bod_en)
    `CHK("wdt_run", 1'b1, wdt_run)
    ignored(4'he);
    pin_wake(1'b0, 70, 73);
    settle(2);
    `CHK("in_buf_en", 16'h7ff0, in_buf_en)
    `CHK("comp_en", 1'b1, comp_en)
    wr(slpm_pkg::OFS_DISA, 32'h00);
    wr(slpm_pkg::OFS_DISB, 32'h00);
  endtask

  task automatic t_stby;
    @(posedge clk);
    xtal_selected <= 1'b1;
    wr(slpm_pkg::OFS_CORE, 32'h38);
    enter(5'b10000, 1'b0);
    pin_wake(1'b1, 8, 11);
  endtask

  // unlock and arm carry the mode so no further write delays the sleep
  task automatic t_bod;
    wr(slpm_pkg::OFS_CORE, 32'hb4);
    wr(slpm_pkg::OFS_CORE, 32'hb0);
    repeat (2) @(posedge clk);
    enter(5'b00000, 1'b0);
    `CHK("bod_en", 1'b0, bod_en)
    pin_wake(1'b0, 602, 605);
    settle(2);
    `CHK("bod_en", 1'b1, bod_en)
  endtask

  task automatic t_analog;
    wr(slpm_pkg::OFS_ACMP, 32'h80);
    settle(2);
    `CHK("comp_en", 1'b0, comp_en)
    @(posedge clk);
    bod_fuse_en <= 1'b0;
    adc_enabled <= 1'b0;
    wdt_enabled <= 1'b0;
    settle(2);
    `CHK("vref_en", 1'b0, vref_en)
    `CHK("bod_en", 1'b0, bod_en)
    `CHK("wdt_run", 1'b0, wdt_run)
    // only the comparator's reference use keeps vref up in deep sleep;
    // mode 11 without a crystal must fall back to power-down
    wr(slpm_pkg::OFS_ACMP, 32'h40);
    @(posedge clk);
    xtal_selected <= 1'b0;
    wr(slpm_pkg::OFS_CORE, 32'h38);
    enter(5'b00000, 1'b0);
    `CHK("vref_en", 1'b1, vref_en)
    `CHK("comp_en", 1'b0, comp_en)
    pin_wake(1'b1, 70, 73);
    wr(slpm_pkg::OFS_ACMP, 32'h80);
    @(posedge clk);
    adc_enabled <= 1'b1;
    settle(2);
    `CHK("vref_en", 1'b1, vref_en)
    wr(slpm_pkg::OFS_ACMP, 32'h00);
    settle(2);
    `CHK("comp_en", 1'b1, comp_en)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sleep_exec = 1'b0;
    wake_src = 4'h0;
    ext0_level_pin = 1'b0;
    pin_change_pin = 1'b0;
    adc_enabled = 1'b0;
    wdt_enabled = 1'b1;
    bod_fuse_en = 1'b1;
    xtal_selected = 1'b0;
    wake_pin_need = 16'h0101;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    t_reset;
    t_refuse;
    t_adc_ext;
    t_idle;
    t_noise;
    t_pclk;
    t_pdown;
    t_stby;
    t_bod;
    t_analog;
    test_done;
  end
endmodule
